// ### hdl/sspc_defs.svh
`ifndef SSPC_DEFS_SVH
`define SSPC_DEFS_SVH
// register addresses on the special function register port
`define SSPC_ADDR_TXBUF 8'h9A
`define SSPC_ADDR_RXBUF 8'h9B
`define SSPC_ADDR_CFG1  8'hE8
`define SSPC_ADDR_CFG2  8'hE9
`define SSPC_ADDR_STAT  8'hEA
// status bits
`define SSPC_ST_RXOF  5
`define SSPC_ST_RXIRQ 4
`define SSPC_ST_RXBF  3
`define SSPC_ST_TXUF  2
`define SSPC_ST_TXIRQ 1
`define SSPC_ST_TXBF  0
// serial_config_one bits
`define SSPC_C1_AUTOSS 4
`define SSPC_C1_SSIN   3
`define SSPC_C1_OVWR   2
// serial_config_two bits
`define SSPC_C2_MASTER 5
`define SSPC_C2_TRANSFER_INTERRUPT_MODE_SELECT 4
`define SSPC_C2_CPOL   3
`define SSPC_C2_CPHA   2
`define SSPC_C2_RATE_H 1
`define SSPC_C2_RATE_L 0
// reset values
`define SSPC_RST_CFG  8'h00
`define SSPC_RST_STAT 6'h00
`define SSPC_RST_BYTE 8'h00
// timing counts
`define SSPC_LAST_EDGE 4'hF
`define SSPC_LAST_BIT  3'h7
`endif

// ### hdl/sspc_pkg.sv
`default_nettype none
package sspc_pkg;
   typedef logic [7:0] sspc_byte_t;
   typedef enum logic [1:0] {
      M_IDLE,
      M_SHIFT,
      M_GAP
   } sspc_mstate_t;
endpackage
`default_nettype wire

// ### hdl/sspc_link_if.sv
`default_nettype none
interface sspc_link_if;
   logic               cpol;
   logic               cpha;
   sspc_pkg::sspc_byte_t tx_word;
   sspc_pkg::sspc_byte_t rx_word;
   logic               done_tgl;
   modport core (output cpol, output cpha, output tx_word, input rx_word, input done_tgl);
   modport link (input cpol, input cpha, input tx_word, output rx_word, output done_tgl);
endinterface
`default_nettype wire

// ### hdl/sspc_link_shift.sv
`include "sspc_defs.svh"
`default_nettype none
module sspc_link_shift (
   // core side
   sspc_link_if.link lnk,
   input  wire logic srst_in,
   // pins
   input  wire logic sclk_in,
   input  wire logic ss_n_in,
   input  wire logic mosi_in,
   output logic      miso_out,
   output logic      miso_oe_out
);
   logic                 samp_clk;
   logic [2:0]           cnt_ff;
   logic [2:0]           nxt_cnt;
   logic [6:0]           sr_ff;
   logic [6:0]           nxt_sr;
   logic                 first_ff;
   logic                 nxt_first;
   sspc_pkg::sspc_byte_t tx_sh_ff;
   sspc_pkg::sspc_byte_t nxt_tx_sh;
   sspc_pkg::sspc_byte_t hold_ff;
   sspc_pkg::sspc_byte_t nxt_hold;
   logic                 tgl_ff;
   logic                 nxt_tgl;
   logic [2:0]           idx_ff;
   sspc_pkg::sspc_byte_t src;

   assign samp_clk = sclk_in ^ (lnk.cpol ^ lnk.cpha);

   always_comb begin
      nxt_cnt = cnt_ff + 3'h1;
      nxt_sr = {sr_ff[5:0], mosi_in};
      nxt_first = first_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_hold = hold_ff;
      nxt_tgl = tgl_ff;
      if (cnt_ff == `SSPC_LAST_BIT) begin
         nxt_first = 1'b0;
         nxt_tx_sh = lnk.tx_word;
         nxt_hold = {sr_ff, mosi_in};
         nxt_tgl = ~tgl_ff;
      end
   end

   always_ff @(posedge samp_clk or posedge ss_n_in) begin
      if (ss_n_in) begin
         cnt_ff <= 3'h0;
         sr_ff <= 7'h00;
         first_ff <= 1'b1;
         tx_sh_ff <= `SSPC_RST_BYTE;
      end else begin
         cnt_ff <= nxt_cnt;
         sr_ff <= nxt_sr;
         first_ff <= nxt_first;
         tx_sh_ff <= nxt_tx_sh;
      end
   end

   always_ff @(posedge samp_clk or posedge srst_in) begin
      if (srst_in) begin
         hold_ff <= `SSPC_RST_BYTE;
         tgl_ff <= 1'b0;
      end else begin
         hold_ff <= nxt_hold;
         tgl_ff <= nxt_tgl;
      end
   end

   always_ff @(negedge samp_clk or posedge ss_n_in) begin
      if (ss_n_in) begin
         idx_ff <= 3'h0;
      end else begin
         idx_ff <= cnt_ff;
      end
   end

   assign src = first_ff ? lnk.tx_word : tx_sh_ff;
   assign miso_out = src[3'h7 - idx_ff];
   assign miso_oe_out = ~ss_n_in;
   assign lnk.rx_word = hold_ff;
   assign lnk.done_tgl = tgl_ff;

   a_link_byte_wrap: assert property (@(posedge samp_clk) disable iff (ss_n_in)
      (cnt_ff == 3'h7) |=> (cnt_ff == 3'h0) && (tgl_ff != $past(tgl_ff)))
      else $error("link byte did not wrap after eight bits");
endmodule
`default_nettype wire

// ### hdl/sspc_top.sv
`include "sspc_defs.svh"
`default_nettype none
module sspc_top #(
   parameter int unsigned DIV_W = 4
) (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   // register port
   input  wire logic [7:0] sfr_addr_in,
   input  wire logic       sfr_wr_in,
   input  wire logic       sfr_rd_in,
   input  wire logic [7:0] sfr_wdata_in,
   output logic [7:0]      sfr_rdata_out,
   // interrupt
   input  wire logic       serial_int_en_in,
   output logic            irq_out,
   // serial clock pin
   input  wire logic       sclk_in,
   output logic            sclk_out,
   output logic            sclk_oe_out,
   // mosi pin
   input  wire logic       mosi_in,
   output logic            mosi_out,
   output logic            mosi_oe_out,
   // miso pin
   input  wire logic       miso_in,
   output logic            miso_out,
   output logic            miso_oe_out,
   // slave select pin
   input  wire logic       ss_n_in,
   output logic            ss_n_out,
   output logic            ss_n_oe_out
);
   if (DIV_W < 4) begin : g_chk
      $error("DIV_W must be at least 4");
   end

   sspc_link_if lnk ();

   logic [7:0]             cfg1_ff;
   logic [7:0]             nxt_cfg1;
   logic [7:0]             cfg2_ff;
   logic [7:0]             nxt_cfg2;
   logic [5:0]             stat_ff;
   logic [5:0]             nxt_stat;
   sspc_pkg::sspc_byte_t   txbuf_ff;
   sspc_pkg::sspc_byte_t   nxt_txbuf;
   sspc_pkg::sspc_byte_t   rxbuf_ff;
   sspc_pkg::sspc_byte_t   nxt_rxbuf;
   logic [7:0]             rdata_ff;
   logic [7:0]             nxt_rdata;
   sspc_pkg::sspc_mstate_t state_ff;
   sspc_pkg::sspc_mstate_t nxt_state;
   logic [DIV_W-1:0]       div_ff;
   logic [DIV_W-1:0]       nxt_div;
   logic [DIV_W-1:0]       reload;
   logic [3:0]             edge_ff;
   logic [3:0]             nxt_edge;
   logic                   sclk_ff;
   logic                   nxt_sclk;
   logic                   ss_ff;
   logic                   nxt_ss;
   sspc_pkg::sspc_byte_t   tx_sr_ff;
   sspc_pkg::sspc_byte_t   nxt_tx_sr;
   sspc_pkg::sspc_byte_t   rx_sr_ff;
   sspc_pkg::sspc_byte_t   nxt_rx_sr;
   logic                   miso_s1_ff;
   logic                   miso_s2_ff;
   logic                   tgl_s1_ff;
   logic                   tgl_s2_ff;
   logic                   tgl_s3_ff;
   logic [1:0]             pend_ff;
   logic [1:0]             nxt_pend;
   logic [1:0]             plast_ff;
   logic [1:0]             nxt_plast;
   logic                   master;
   logic                   transfer_interrupt_mode_select;
   logic                   cpol;
   logic                   cpha;
   logic                   auto_ss;
   logic                   ss_input;
   logic                   wr_tx;
   logic                   wr_st;
   logic                   wr_c1;
   logic                   wr_c2;
   logic                   rd_rx;
   logic                   rx_unread;
   logic                   go;
   logic                   byte_end;
   logic                   m_take;
   logic                   m_under;
   logic                   m_put;
   logic                   s_evt;
   logic                   rx_put;
   logic                   tx_take;
   logic                   tx_under;
   sspc_pkg::sspc_byte_t   rx_new;
   logic                   l_miso;
   logic                   l_miso_oe;

   assign master = cfg2_ff[`SSPC_C2_MASTER];
   assign transfer_interrupt_mode_select = cfg2_ff[`SSPC_C2_TRANSFER_INTERRUPT_MODE_SELECT];
   assign cpol = cfg2_ff[`SSPC_C2_CPOL];
   assign cpha = cfg2_ff[`SSPC_C2_CPHA];
   assign auto_ss = cfg1_ff[`SSPC_C1_AUTOSS];
   assign ss_input = cfg1_ff[`SSPC_C1_SSIN];

   assign wr_tx = sfr_wr_in && (sfr_addr_in == `SSPC_ADDR_TXBUF);
   assign wr_st = sfr_wr_in && (sfr_addr_in == `SSPC_ADDR_STAT);
   assign wr_c1 = sfr_wr_in && (sfr_addr_in == `SSPC_ADDR_CFG1);
   assign wr_c2 = sfr_wr_in && (sfr_addr_in == `SSPC_ADDR_CFG2);
   assign rd_rx = sfr_rd_in && (sfr_addr_in == `SSPC_ADDR_RXBUF);
   assign rx_unread = stat_ff[`SSPC_ST_RXIRQ] && !rd_rx;

   // half period of 2^rate core cycles
   assign reload = DIV_W'((32'h1 << cfg2_ff[`SSPC_C2_RATE_H:`SSPC_C2_RATE_L]) - 32'h1);

   // mode 0 needs the last byte read
   // mode 1 needs a fresh transmit byte
   assign go = stat_ff[`SSPC_ST_TXBF] && (transfer_interrupt_mode_select || !rx_unread);

   // miso pin and link toggle synchronisers
   always_ff @(posedge clk_in) begin
      miso_s1_ff <= miso_in;
      miso_s2_ff <= miso_s1_ff;
      tgl_s1_ff <= lnk.done_tgl;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
   end

   // master engine
   always_comb begin
      nxt_state = state_ff;
      nxt_div = div_ff;
      nxt_edge = edge_ff;
      nxt_sclk = sclk_ff;
      nxt_ss = ss_ff;
      nxt_tx_sr = tx_sr_ff;
      nxt_rx_sr = rx_sr_ff;
      m_take = 1'b0;
      m_under = 1'b0;
      byte_end = 1'b0;
      nxt_pend = {pend_ff[0], 1'b0};
      nxt_plast = {plast_ff[0], 1'b0};
      m_put = pend_ff[1] && plast_ff[1];
      if (pend_ff[1]) begin
         nxt_rx_sr = {rx_sr_ff[6:0], miso_s2_ff};
      end
      unique case (state_ff)
         sspc_pkg::M_IDLE: begin
            nxt_sclk = cpol;
            nxt_ss = 1'b1;
            if (master && stat_ff[`SSPC_ST_TXBF]) begin
               nxt_state = sspc_pkg::M_SHIFT;
               nxt_div = reload;
               nxt_edge = 4'h0;
               nxt_tx_sr = txbuf_ff;
               m_take = 1'b1;
               nxt_ss = ~auto_ss;
            end
         end
         sspc_pkg::M_SHIFT: begin
            if (div_ff == {DIV_W{1'b0}}) begin
               nxt_div = reload;
               nxt_sclk = ~sclk_ff;
               nxt_edge = edge_ff + 4'h1;
               if (edge_ff[0] == cpha) begin
                  nxt_pend[0] = 1'b1;
                  nxt_plast[0] = (edge_ff[3:1] == 3'h7);
               end else if (!(cpha && (edge_ff == 4'h0))) begin
                  nxt_tx_sr = {tx_sr_ff[6:0], 1'b0};
               end
               if (edge_ff == `SSPC_LAST_EDGE) begin
                  byte_end = 1'b1;
                  if (go) begin
                     nxt_tx_sr = txbuf_ff;
                     m_take = 1'b1;
                  end else begin
                     nxt_state = sspc_pkg::M_GAP;
                     nxt_ss = 1'b1;
                     m_under = ~stat_ff[`SSPC_ST_TXBF];
                  end
               end
            end else begin
               nxt_div = div_ff - {{(DIV_W-1){1'b0}}, 1'b1};
            end
         end
         sspc_pkg::M_GAP: begin
            if (div_ff == {DIV_W{1'b0}}) begin
               nxt_state = sspc_pkg::M_IDLE;
            end else begin
               nxt_div = div_ff - {{(DIV_W-1){1'b0}}, 1'b1};
            end
         end
      endcase
      if (!master) begin
         nxt_state = sspc_pkg::M_IDLE;
         nxt_ss = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_ff <= sspc_pkg::M_IDLE;
         div_ff <= {DIV_W{1'b0}};
         edge_ff <= 4'h0;
         sclk_ff <= 1'b0;
         ss_ff <= 1'b1;
         tx_sr_ff <= `SSPC_RST_BYTE;
         rx_sr_ff <= `SSPC_RST_BYTE;
         pend_ff <= 2'h0;
         plast_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         div_ff <= nxt_div;
         edge_ff <= nxt_edge;
         sclk_ff <= nxt_sclk;
         ss_ff <= nxt_ss;
         tx_sr_ff <= nxt_tx_sr;
         rx_sr_ff <= nxt_rx_sr;
         pend_ff <= nxt_pend;
         plast_ff <= nxt_plast;
      end
   end

   // slave byte events arrive by toggle
   assign s_evt = (tgl_s2_ff ^ tgl_s3_ff) && !master;
   assign rx_put = m_put || s_evt;
   assign rx_new = master ? nxt_rx_sr : lnk.rx_word;
   assign tx_take = m_take || (s_evt && stat_ff[`SSPC_ST_TXBF]);
   assign tx_under = m_under || (s_evt && !stat_ff[`SSPC_ST_TXBF]);

   // registers and flags
   always_comb begin
      nxt_cfg1 = cfg1_ff;
      nxt_cfg2 = cfg2_ff;
      nxt_stat = stat_ff;
      nxt_txbuf = txbuf_ff;
      nxt_rxbuf = rxbuf_ff;
      if (wr_c1) begin
         nxt_cfg1 = sfr_wdata_in;
      end
      if (wr_c2) begin
         nxt_cfg2 = sfr_wdata_in;
      end
      if (wr_st) begin
         nxt_stat[2:0] = stat_ff[2:0] & sfr_wdata_in[2:0];
      end
      if (rd_rx) begin
         nxt_stat[`SSPC_ST_RXOF] = 1'b0;
         nxt_stat[`SSPC_ST_RXIRQ] = 1'b0;
         nxt_stat[`SSPC_ST_RXBF] = 1'b0;
      end
      if (tx_under) begin
         nxt_stat[`SSPC_ST_TXUF] = 1'b1;
      end
      if (tx_take) begin
         nxt_stat[`SSPC_ST_TXIRQ] = 1'b1;
         nxt_stat[`SSPC_ST_TXBF] = 1'b0;
      end
      if (wr_tx) begin
         nxt_txbuf = sfr_wdata_in;
         nxt_stat[`SSPC_ST_TXIRQ] = 1'b0;
         nxt_stat[`SSPC_ST_TXBF] = 1'b1;
      end
      if (rx_put) begin
         if (rx_unread) begin
            if (transfer_interrupt_mode_select) begin
               nxt_stat[`SSPC_ST_RXOF] = 1'b1;
            end
            if (cfg1_ff[`SSPC_C1_OVWR]) begin
               nxt_rxbuf = rx_new;
            end
         end else begin
            nxt_rxbuf = rx_new;
         end
         nxt_stat[`SSPC_ST_RXIRQ] = 1'b1;
         nxt_stat[`SSPC_ST_RXBF] = 1'b1;
      end
      unique case (sfr_addr_in)
         `SSPC_ADDR_STAT:  nxt_rdata = {2'h0, stat_ff};
         `SSPC_ADDR_CFG1:  nxt_rdata = cfg1_ff;
         `SSPC_ADDR_CFG2:  nxt_rdata = cfg2_ff;
         `SSPC_ADDR_RXBUF: nxt_rdata = rxbuf_ff;
         default:          nxt_rdata = 8'h00;
      endcase
      if (!sfr_rd_in) begin
         nxt_rdata = rdata_ff;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cfg1_ff <= `SSPC_RST_CFG;
         cfg2_ff <= `SSPC_RST_CFG;
         stat_ff <= `SSPC_RST_STAT;
         txbuf_ff <= `SSPC_RST_BYTE;
         rxbuf_ff <= `SSPC_RST_BYTE;
         rdata_ff <= 8'h00;
      end else begin
         cfg1_ff <= nxt_cfg1;
         cfg2_ff <= nxt_cfg2;
         stat_ff <= nxt_stat;
         txbuf_ff <= nxt_txbuf;
         rxbuf_ff <= nxt_rxbuf;
         rdata_ff <= nxt_rdata;
      end
   end

   // request from the flag of this mode
   assign irq_out = serial_int_en_in && (transfer_interrupt_mode_select ? stat_ff[`SSPC_ST_TXIRQ] : stat_ff[`SSPC_ST_RXIRQ]);

   // slave shifter clocked by the pin clock
   assign lnk.cpol = cpol;
   assign lnk.cpha = cpha;
   assign lnk.tx_word = txbuf_ff;

   sspc_link_shift u_link (
      .lnk         (lnk),
      .srst_in     (srst_in),
      .sclk_in     (sclk_in),
      .ss_n_in     (ss_n_in),
      .mosi_in     (mosi_in),
      .miso_out    (l_miso),
      .miso_oe_out (l_miso_oe)
   );

   assign sclk_out = sclk_ff;
   assign sclk_oe_out = master;
   assign mosi_out = tx_sr_ff[7];
   assign mosi_oe_out = master;
   assign miso_out = l_miso;
   assign miso_oe_out = !master && l_miso_oe;
   assign ss_n_out = ss_ff;
   assign ss_n_oe_out = master && !ss_input;
   assign sfr_rdata_out = rdata_ff;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   a_rx_flag_irq: assert property ((rx_put && !transfer_interrupt_mode_select && serial_int_en_in) |=>
      (irq_out || !serial_int_en_in) && stat_ff[`SSPC_ST_RXIRQ])
      else $error("receive flag or request missing");
   a_mode0_stop: assert property ((byte_end && !transfer_interrupt_mode_select && rx_unread) |=>
      (state_ff == sspc_pkg::M_GAP) && ss_n_out)
      else $error("mode 0 did not stop on unread byte");
   a_rx_read_clr: assert property ((rd_rx && !rx_put) |=>
      !stat_ff[`SSPC_ST_RXBF] && !stat_ff[`SSPC_ST_RXIRQ] && !stat_ff[`SSPC_ST_RXOF])
      else $error("receive read did not clear flags");
   a_txuf_clear: assert property ((wr_st && !sfr_wdata_in[2] && !tx_under) |=> !stat_ff[`SSPC_ST_TXUF])
      else $error("underflow not cleared by zero write");
   a_tx_write_clr: assert property (wr_tx |=> !stat_ff[`SSPC_ST_TXIRQ] && stat_ff[`SSPC_ST_TXBF]
      && (txbuf_ff == $past(sfr_wdata_in)))
      else $error("transmit write did not update flags");
   a_tx_flag_irq: assert property ((tx_take && !wr_tx && transfer_interrupt_mode_select && serial_int_en_in) |=>
      (irq_out || !serial_int_en_in))
      else $error("transmit request missing");
   a_mode1_stop: assert property ((byte_end && transfer_interrupt_mode_select && !stat_ff[`SSPC_ST_TXBF]) |=>
      (state_ff == sspc_pkg::M_GAP) ##1 stat_ff[`SSPC_ST_TXUF] || state_ff != sspc_pkg::M_SHIFT)
      else $error("mode 1 did not stop without new byte");
   a_pin_dirs: assert property (master |-> sclk_oe_out && mosi_oe_out && !miso_oe_out)
      else $error("master pin directions wrong");
   a_slave_inputs: assert property (!master |-> !sclk_oe_out && !mosi_oe_out && !ss_n_oe_out)
      else $error("slave drives a master pin");
   a_byte_edges: assert property (($rose(state_ff == sspc_pkg::M_SHIFT) && reload == 4'h0) |->
      (state_ff == sspc_pkg::M_SHIFT) [*8] ##0 (edge_ff == 4'h7))
      else $error("master byte edge count wrong");
   a_auto_select: assert property ((master && auto_ss && (state_ff == sspc_pkg::M_SHIFT)) |-> !ss_n_out)
      else $error("automatic select not low in transfer");
   a_overflow_set: assert property ((rx_put && rx_unread && transfer_interrupt_mode_select) |=> stat_ff[`SSPC_ST_RXOF])
      else $error("overflow flag not set");

   c_master_chain: cover property (byte_end && go);
   c_overflow: cover property (rx_put && rx_unread && transfer_interrupt_mode_select);
   c_slave_byte: cover property (s_evt);
   c_underflow: cover property (tx_under);
endmodule
`default_nettype wire

// ### tb/sspc_partner.sv
`default_nettype none
module sspc_partner (
   // device acting as master
   input  wire logic       sclk_in,
   input  wire logic       ss_n_in,
   input  wire logic       mosi_in,
   input  wire logic [7:0] reply_in,
   output logic            miso_out,
   // device acting as slave
   input  wire logic       miso_in,
   output logic            sclk_out,
   output logic            ss_n_out,
   output logic            mosi_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sh;
   logic [7:0] acc;
   logic       mst;
   int         cnt;
   logic [7:0] got[$];
   initial begin
      miso_out = 1'b0;
      sclk_out = 1'b0;
      ss_n_out = 1'b1;
      mosi_out = 1'b0;
      mst = 1'b0;
      cnt = 0;
   end
   always @(negedge ss_n_in) begin
      cnt = 0;
      sh = reply_in;
      miso_out = sh[7];
   end
   always @(posedge sclk_in) if (!ss_n_in && !mst) begin
      acc = {acc[6:0], mosi_in};
      cnt = cnt + 1;
      if (cnt == 8) begin
         got.push_back(acc);
         cnt = 0;
      end
   end
   // launch on fall, reload per byte
   always @(negedge sclk_in) if (!ss_n_in) begin
      sh = (cnt == 0) ? reply_in : {sh[6:0], 1'b0};
      miso_out = sh[7];
   end
   // released line shows the inverse
   always @(posedge ss_n_in) miso_out = ~miso_out;
   // select low frames one byte, clock still outside
   task xfer(input logic [7:0] tx, output logic [7:0] rx);
      mst = 1'b1;
      ss_n_out = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_out = tx[i];
         #15 sclk_out = 1'b1;
         rx[i] = miso_in;
         #15 sclk_out = 1'b0;
      end
      #15 ss_n_out = 1'b1;
      mosi_out = ~mosi_out;
      mst = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb/tb_sspc_top.sv
`include "sspc_defs.svh"
`default_nettype none
module tb_sspc_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_in;
   logic       srst_in;
   logic [7:0] sfr_addr_in;
   logic       sfr_wr_in;
   logic       sfr_rd_in;
   logic [7:0] sfr_wdata_in;
   logic [7:0] sfr_rdata_out;
   logic       serial_int_en_in;
   logic       irq_out;
   logic       sclk_out, sclk_oe_out, mosi_out, mosi_oe_out;
   logic       miso_out, miso_oe_out, ss_n_out, ss_n_oe_out;
   logic       p_sclk, p_ss_n, p_mosi, p_miso;
   logic [7:0] reply;
   logic [7:0] exp_q[$];
   int         bad_count;
   int         comparisons;
   int         ss_rises;
   wire logic  sclk_w = sclk_oe_out ? sclk_out : p_sclk;
   wire logic  ss_w = ss_n_oe_out ? ss_n_out : p_ss_n;
   wire logic  mosi_w = mosi_oe_out ? mosi_out : p_mosi;
   wire logic  miso_w = miso_oe_out ? miso_out : p_miso;
   sspc_top #(.DIV_W(4)) sspc_top_i (
      .clk_in(clk_in), .srst_in(srst_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
      .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
      .serial_int_en_in(serial_int_en_in), .irq_out(irq_out), .sclk_in(sclk_w), .sclk_out(sclk_out),
      .sclk_oe_out(sclk_oe_out), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out),
      .miso_in(miso_w), .miso_out(miso_out), .miso_oe_out(miso_oe_out), .ss_n_in(ss_w),
      .ss_n_out(ss_n_out), .ss_n_oe_out(ss_n_oe_out));
   sspc_partner sspc_partner_i (
      .sclk_in(sclk_w), .ss_n_in(ss_w), .mosi_in(mosi_w), .reply_in(reply), .miso_out(p_miso),
      .miso_in(miso_w), .sclk_out(p_sclk), .ss_n_out(p_ss_n), .mosi_out(p_mosi));
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge ss_n_out) ss_rises++;
   task conclude();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in) #2 sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      @(posedge clk_in) #2 sfr_wr_in = 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in) #2 sfr_addr_in = a;
      sfr_rd_in = 1'b1;
      @(posedge clk_in) #2 sfr_rd_in = 1'b0;
      d = sfr_rdata_out;
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] want);
      logic [7:0] d;
      rd(a, d);
      check(d, want);
   endtask
   task wait_bit(input int b, input logic val);
      logic [7:0] s;
      for (int i = 0; i < 150; i++) begin
         rd(`SSPC_ADDR_STAT, s);
         if (s[b] === val) return;
      end
      bad_count++;
      conclude();
   endtask
   // master transfer of n bytes in the given interrupt mode
   task mrun(input logic md, input int n, input logic [1:0] rt);
      logic [7:0] t;
      ss_rises = 0;
      reply = 8'($urandom);
      wr(`SSPC_ADDR_CFG1, 8'h10);
      wr(`SSPC_ADDR_CFG2, {2'b00, 1'b1, md, 2'b00, rt});
      for (int k = 0; k < n; k++) begin
         t = 8'($urandom);
         exp_q.push_back(t);
         if (k > 0) begin
            wait_bit(`SSPC_ST_TXBF, 1'b0);
            check(irq_out, md || k > 1);
            wr(`SSPC_ADDR_TXBUF, t);
            @(posedge clk_in) #2 check(irq_out, !md && k > 1);
         end else wr(`SSPC_ADDR_TXBUF, t);
      end
      wait_bit(`SSPC_ST_TXUF, 1'b1);
      repeat (4) @(posedge clk_in);
      check(8'(ss_rises), (!md && n > 2) ? 8'h02 : 8'h01);
      rd_chk(`SSPC_ADDR_STAT, {2'b00, md && n > 1, 5'h1E});
      check(irq_out, 1'b1);
      serial_int_en_in = 1'b0;
      @(posedge clk_in) #2 check(irq_out, 1'b0);
      serial_int_en_in = 1'b1;
      rd_chk(`SSPC_ADDR_RXBUF, reply);
      rd_chk(`SSPC_ADDR_STAT, 8'h06);
      wr(`SSPC_ADDR_STAT, 8'h00);
      rd_chk(`SSPC_ADDR_STAT, 8'h00);
      check(irq_out, 1'b0);
      check(8'(sspc_partner_i.got.size()), 8'(exp_q.size()));
      while (exp_q.size() > 0) check(sspc_partner_i.got.pop_front(), exp_q.pop_front());
   endtask
   initial begin
      logic [7:0] v;
      logic [7:0] t;
      logic [7:0] m;
      logic [7:0] addrs[6] = '{`SSPC_ADDR_TXBUF, `SSPC_ADDR_RXBUF, `SSPC_ADDR_CFG1,
                               `SSPC_ADDR_CFG2, `SSPC_ADDR_STAT, 8'h00};
      logic [7:0] c1[3] = '{8'h10, 8'h08, 8'h00};
      logic [7:0] c2[3] = '{8'h20, 8'h20, 8'h00};
      logic [3:0] oe[3] = '{4'hD, 4'hC, 4'h0};
      srst_in = 1'b0;
      sfr_addr_in = 8'h00;
      sfr_wr_in = 1'b0;
      sfr_rd_in = 1'b0;
      sfr_wdata_in = 8'h00;
      serial_int_en_in = 1'b1;
      reply = 8'h00;
      v = $urandom(11672);
      // a real rising edge also clears the link side
      #2 srst_in = 1'b1;
      repeat (12) @(posedge clk_in);
      #2 srst_in = 1'b0;
      foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(`SSPC_ADDR_CFG1, c1[i]);
         wr(`SSPC_ADDR_CFG2, c2[i]);
         @(posedge clk_in) #2 check({sclk_oe_out, mosi_oe_out, miso_oe_out, ss_n_oe_out}, oe[i]);
      end
      mrun(1'b0, 1, 2'h3);
      mrun(1'b0, 2, 2'h0);
      mrun(1'b0, 3, 2'h1);
      mrun(1'b1, 2, 2'h2);
      mrun(1'b1, 1, 2'h0);
      wr(`SSPC_ADDR_CFG1, 8'h00);
      wr(`SSPC_ADDR_CFG2, 8'h00);
      for (int k = 0; k < 2; k++) begin
         t = 8'($urandom);
         m = 8'($urandom);
         wr(`SSPC_ADDR_TXBUF, t);
         rd_chk(`SSPC_ADDR_STAT, 8'h01);
         sspc_partner_i.xfer(m, v);
         check(v, t);
         wait_bit(`SSPC_ST_RXIRQ, 1'b1);
         rd_chk(`SSPC_ADDR_RXBUF, m);
         wr(`SSPC_ADDR_STAT, 8'h00);
      end
      conclude();
   end
endmodule
`default_nettype wire
